// file: design/tlp_pkg.sv
// Shared constants and types of the timer with stop and wait low-power modes.
package tlp_pkg;

    // ========================================================================
    // Register map (Avalon-MM byte addresses)
    // ========================================================================
    localparam logic [3:0] TLP_OFF_CTRL  = 4'h0;
    localparam logic [3:0] TLP_OFF_COUNT = 4'h4;
    localparam logic [3:0] TLP_OFF_MODE  = 4'h8;

    // ========================================================================
    // Timer control fields
    // ========================================================================
    localparam int TLP_TCR_REQ   = 7;
    localparam int TLP_TCR_MASK  = 6;
    localparam int TLP_TCR_SRC   = 5;
    localparam int TLP_TCR_PINEN = 4;
    localparam int TLP_TCR_PCLR  = 3;
    localparam int TLP_TCR_DIVHI = 2;

    // ========================================================================
    // Mode register fields
    // ========================================================================
    localparam int TLP_MODE_IBIT = 0;
    localparam int TLP_MODE_STOP = 1;
    localparam int TLP_MODE_WAIT = 2;
    localparam int TLP_MODE_EXT  = 3;

    // ========================================================================
    // Values after reset, vectors and timing
    // ========================================================================
    localparam logic [7:0]  TLP_COUNT_RST = 8'hf0;
    localparam logic        TLP_REQ_RST   = 1'h0;
    localparam logic        TLP_MASK_RST  = 1'h1;
    localparam logic        TLP_IBIT_RST  = 1'h1;
    localparam logic [12:0] TLP_VEC_TIMER = 13'h1ff8;
    localparam logic [12:0] TLP_VEC_TWAIT = 13'h1ff6;
    localparam logic [12:0] TLP_VEC_EXT   = 13'h1ffa;
    localparam int          TLP_CYC_DIV   = 5;
    localparam int          TLP_PRE_BITS  = 7;

    typedef enum logic [1:0] {
        TLP_RUN  = 2'b00,
        TLP_WAIT = 2'b01,
        TLP_STOP = 2'b10
    } tlp_mode_e;

endpackage : tlp_pkg

// file: design/tlp_presc_if.sv
// Link between the timer core and its prescaler.
`timescale 1ns/1ns
interface tlp_presc_if;
    logic       tickIn;
    logic       clear;
    logic [2:0] divSel;
    logic       tickOut;

    modport ctl   (output tickIn, output clear, output divSel, input tickOut);
    modport presc (input tickIn, input clear, input divSel, output tickOut);
endinterface : tlp_presc_if

// file: design/tlp_prescaler.sv
// Seven-bit prescaler with eight selectable power-of-two taps.
`timescale 1ns/1ns
module tlp_prescaler (
    input  wire logic clk_sys,   // System clock.
    input  wire logic rst_n,     // Asynchronous reset, active low.
    tlp_presc_if.presc pif       // Tick in, clear, tap select and tick out.
);
    typedef struct packed {
        logic [tlp_pkg::TLP_PRE_BITS-1:0] cnt;
    } tlp_pre_s;

    tlp_pre_s st_q;
    tlp_pre_s st_d;
    logic [tlp_pkg::TLP_PRE_BITS-1:0] tapMask;

    // ========================================================================
    // Divider
    // ========================================================================
    always_comb begin
        st_d    = st_q;
        tapMask = tlp_pkg::TLP_PRE_BITS'((8'h01 << pif.divSel) - 8'h01);
        if (pif.clear) begin
            st_d.cnt = '0;
        end else if (pif.tickIn) begin
            st_d.cnt = st_q.cnt + 7'h01;
        end
    end

    // A tap fires when all counter bits below it are ones, so ratio is 2^sel.
    assign pif.tickOut = pif.tickIn && ((st_q.cnt | ~tapMask) == '1);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ========================================================================
    // Assertions
    // ========================================================================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_presc_div_one: assert property (pif.divSel == 3'h0 |-> pif.tickOut == pif.tickIn)
        else $error("Undivided tap does not follow its input.");
    a_presc_clear_zero: assert property (pif.clear |=> st_q.cnt == 7'h00)
        else $error("Prescaler not cleared.");
    a_presc_max_div: assert property (pif.divSel == 3'h7 && pif.tickOut |-> st_q.cnt == 7'h7f)
        else $error("Divide by 128 tap fired early.");

endmodule : tlp_prescaler

// file: design/tlp_timer_lpm.sv
// Timer, prescaler control and stop/wait low-power mode logic with an Avalon-MM slave.
// Function
// - Stop halts clock, processing, timer; idles bus.
// - Stop ends only on external interrupt or reset.
// - Stop clears request, sets mask, clears I.
// - Wait keeps timer counting; bus pins idle.
// - Wait ends on external, timer interrupt, reset.
// - Entering wait clears the processor interrupt mask.
// - External first; pending timer later uses normal vector.
// - Timer vector 1FF8; wait wake-up vector 1FF6.
// - Presettable 8-bit down counter; zero step sets request.
// - Interrupt only when both masks are clear.
// - Counter keeps decrementing after reaching zero.
// - Counter read is stable and undisturbing.
// - Request stays set until software clears it.
// - Three low bits select divide 1 to 128.
// - Prescaler hidden; bit 3 write clears; reads zero.
// - Source and pin-enable bits pick timer input.
// - Timer clock is instruction cycle, runs in wait.
// - Reset and stop load counter with F0.
// - Prescaler and counter advance on input falling edge.
// - Resets and stop clear request, set mask.
// - Counter write loads value, counting continues; the code ignores counter writes in stop.
// - All control bits except bit 3 read/write.
//
// The register offsets and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ns
module tlp_timer_lpm #(
    parameter int CYC_DIV = tlp_pkg::TLP_CYC_DIV   // System clocks per instruction cycle.
) (
    input  wire logic        clk_sys,         // System clock, 20 MHz.
    input  wire logic        rst_n,           // Power-on or external reset, active low.
    input  wire logic [3:0]  avs_address,     // Avalon byte address.
    input  wire logic        avs_read,        // Avalon read request.
    input  wire logic        avs_write,       // Avalon write request.
    input  wire logic [31:0] avs_writedata,   // Avalon write data.
    input  wire logic [3:0]  avs_byteenable,  // Avalon byte enables.
    output logic      [31:0] avs_readdata,    // Avalon read data.
    output logic             avs_waitrequest, // Avalon wait request.
    input  wire logic        timerPin,        // Timer input pin, asynchronous.
    input  wire logic        extIrq_n,        // External interrupt pin, active low.
    input  wire logic        intAck,          // Core takes the offered interrupt.
    input  wire logic        coreRw,          // Core read/write level in run mode.
    input  wire logic        coreBusOe,       // Core bus drive enable in run mode.
    output logic             cpuIrq,          // Interrupt offered to the core.
    output logic      [12:0] vecAddr,         // Vector of the offered interrupt.
    output logic             addressStrobe,   // Address strobe pin.
    output logic             dataStrobe,      // Data strobe pin.
    output logic             rwOut,           // Read/write pin, high for read.
    output logic             busOe,           // Multiplexed bus output enable.
    output logic             coreHalt         // Core processing halted.
);
    localparam int CW = (CYC_DIV > 1) ? $clog2(CYC_DIV) : 1;
    localparam logic [CW-1:0] CYC_LAST = CW'(CYC_DIV - 1);
    localparam logic TLP_REQ_CONST = tlp_pkg::TLP_REQ_RST;

    generate
        if (CYC_DIV < 2) begin : g_bad_div
            $error("CYC_DIV must be at least 2.");
        end
    endgenerate

    typedef struct packed {
        tlp_pkg::tlp_mode_e mode;
        logic          ccI;
        logic          tReq;
        logic          tMask;
        logic          tSrc;
        logic          tPinEn;
        logic [2:0]    div;
        logic [7:0]    count;
        logic [1:0]    extSync;
        logic [1:0]    pinSync;
        logic          pinPrev;
        logic [CW-1:0] cyc;
        logic          extLatch;
        logic          waitTimerVec;
        logic          ack;
        logic [31:0]   rdata;
        logic [12:0]   vec;
        logic          asO;
        logic          dsO;
        logic          rwO;
        logic          oeO;
    } tlp_state_s;

    tlp_state_s  st_q;
    tlp_state_s  st_d;
    tlp_presc_if pif ();

    logic wrDo;
    logic wrCtrl;
    logic wrCount;
    logic wrMode;
    logic intTick;
    logic pinLevel;
    logic pinFall;
    logic timerPend;
    logic zeroStep;
    logic irqTake;
    logic [7:0] wdat;

    // ========================================================================
    // Bus slave
    // ========================================================================
    assign avs_waitrequest = (avs_read || avs_write) && !st_q.ack;
    assign avs_readdata    = st_q.rdata;
    assign wrDo    = avs_write && st_q.ack && avs_byteenable[0];
    assign wdat    = avs_writedata[7:0];
    assign wrCtrl  = wrDo && (avs_address == tlp_pkg::TLP_OFF_CTRL);
    assign wrCount = wrDo && (avs_address == tlp_pkg::TLP_OFF_COUNT);
    assign wrMode  = wrDo && (avs_address == tlp_pkg::TLP_OFF_MODE);

    // ========================================================================
    // Timer input selection
    // ========================================================================
    assign intTick  = (st_q.mode != tlp_pkg::TLP_STOP) && (st_q.cyc == CYC_LAST);
    assign pinLevel = st_q.pinSync[1];
    assign pinFall  = st_q.pinPrev && !st_q.pinSync[1];

    always_comb begin
        pif.tickIn = 1'b0;
        if (st_q.mode != tlp_pkg::TLP_STOP) begin
            case ({st_q.tSrc, st_q.tPinEn})
                2'b00:   pif.tickIn = intTick;
                2'b01:   pif.tickIn = intTick && pinLevel;
                2'b10:   pif.tickIn = 1'b0;
                2'b11:   pif.tickIn = pinFall;
                default: pif.tickIn = 1'b0;
            endcase
        end
    end

    assign pif.clear  = wrCtrl && wdat[tlp_pkg::TLP_TCR_PCLR];
    assign pif.divSel = st_q.div;
    assign zeroStep   = pif.tickOut && (st_q.count == 8'h01);
    assign timerPend  = st_q.tReq && !st_q.tMask;
    assign cpuIrq     = (st_q.mode == tlp_pkg::TLP_RUN) && !st_q.ccI
                        && (st_q.extLatch || timerPend);
    assign irqTake    = cpuIrq && intAck;

    tlp_prescaler u_presc (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .pif     (pif.presc)
    );

    // ========================================================================
    // Next state
    // ========================================================================
    always_comb begin
        st_d         = st_q;
        st_d.extSync = {st_q.extSync[0], extIrq_n};
        st_d.pinSync = {st_q.pinSync[0], timerPin};
        st_d.pinPrev = st_q.pinSync[1];
        st_d.ack     = (avs_read || avs_write) && !st_q.ack;

        // Instruction cycle divider; the oscillator is off in stop.
        if (st_q.mode != tlp_pkg::TLP_STOP) begin
            st_d.cyc = (st_q.cyc == CYC_LAST) ? '0 : st_q.cyc + CW'(1);
        end

        // Counter: a write wins over a step and counting goes on afterwards.
        if (wrCount && st_q.mode != tlp_pkg::TLP_STOP) begin
            st_d.count = wdat;
        end else if (pif.tickOut) begin
            st_d.count = st_q.count - 8'h01;
        end

        // Control register writes.
        if (wrCtrl) begin
            st_d.tReq   = wdat[tlp_pkg::TLP_TCR_REQ];
            st_d.tMask  = wdat[tlp_pkg::TLP_TCR_MASK];
            st_d.tSrc   = wdat[tlp_pkg::TLP_TCR_SRC];
            st_d.tPinEn = wdat[tlp_pkg::TLP_TCR_PINEN];
            st_d.div    = wdat[tlp_pkg::TLP_TCR_DIVHI:0];
        end
        if (zeroStep) begin
            st_d.tReq = 1'b1;
        end
        if (wrMode) begin
            st_d.ccI = wdat[tlp_pkg::TLP_MODE_IBIT];
        end

        // Interrupt acceptance: external first, then timer.
        if (irqTake) begin
            st_d.ccI = 1'b1;
            if (st_q.extLatch) begin
                st_d.extLatch = 1'b0;
            end else begin
                st_d.waitTimerVec = 1'b0;
            end
        end

        // A pin still low at acceptance keeps the latch set: the set wins.
        if (st_q.extSync[1] == 1'b0) begin
            st_d.extLatch = 1'b1;
        end

        // Low-power mode sequencing.
        // Stop entry overrides a same-cycle zero-step set and the I set by acceptance.
        case (st_q.mode)
            tlp_pkg::TLP_RUN: begin
                if (wrMode && wdat[tlp_pkg::TLP_MODE_STOP]) begin
                    st_d.mode  = tlp_pkg::TLP_STOP;
                    st_d.tReq  = TLP_REQ_CONST;
                    st_d.tMask = tlp_pkg::TLP_MASK_RST;
                    st_d.ccI   = 1'b0;
                    st_d.count = tlp_pkg::TLP_COUNT_RST;
                end else if (wrMode && wdat[tlp_pkg::TLP_MODE_WAIT]) begin
                    st_d.mode = tlp_pkg::TLP_WAIT;
                    st_d.ccI  = 1'b0;
                end
            end
            tlp_pkg::TLP_WAIT: begin
                if (st_q.extLatch) begin
                    st_d.mode = tlp_pkg::TLP_RUN;
                end else if (timerPend) begin
                    st_d.mode         = tlp_pkg::TLP_RUN;
                    st_d.waitTimerVec = 1'b1;
                end
            end
            tlp_pkg::TLP_STOP: begin
                if (st_q.extLatch) begin
                    st_d.mode = tlp_pkg::TLP_RUN;
                end
            end
            default: st_d.mode = tlp_pkg::TLP_RUN;
        endcase

        // Vector offered to the core.
        if (st_d.extLatch) begin
            st_d.vec = tlp_pkg::TLP_VEC_EXT;
        end else if (st_d.waitTimerVec) begin
            st_d.vec = tlp_pkg::TLP_VEC_TWAIT;
        end else begin
            st_d.vec = tlp_pkg::TLP_VEC_TIMER;
        end

        // Bus pins idle in both low-power modes.
        if (st_d.mode == tlp_pkg::TLP_RUN) begin
            st_d.asO = (st_d.cyc == '0);
            st_d.dsO = (st_d.cyc == CYC_LAST);
            st_d.rwO = coreRw;
            st_d.oeO = coreBusOe;
        end else begin
            st_d.asO = 1'b0;
            st_d.dsO = 1'b0;
            st_d.rwO = 1'b1;
            st_d.oeO = 1'b0;
        end

        // Read data is captured a cycle before it is presented.
        if (avs_read && !st_q.ack) begin
            case (avs_address)
                tlp_pkg::TLP_OFF_CTRL:
                    st_d.rdata = {24'h000000, st_q.tReq, st_q.tMask, st_q.tSrc,
                                  st_q.tPinEn, 1'b0, st_q.div};
                tlp_pkg::TLP_OFF_COUNT:
                    st_d.rdata = {24'h000000, st_q.count};
                tlp_pkg::TLP_OFF_MODE:
                    st_d.rdata = {28'h0000000, st_q.extLatch,
                                  st_q.mode == tlp_pkg::TLP_WAIT,
                                  st_q.mode == tlp_pkg::TLP_STOP, st_q.ccI};
                default:
                    st_d.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q       <= '0;
            st_q.mode  <= tlp_pkg::TLP_RUN;
            st_q.ccI   <= tlp_pkg::TLP_IBIT_RST;
            st_q.tReq  <= tlp_pkg::TLP_REQ_RST;
            st_q.tMask <= tlp_pkg::TLP_MASK_RST;
            st_q.count <= tlp_pkg::TLP_COUNT_RST;
            st_q.extSync <= 2'h3;
            st_q.pinSync <= 2'h0;
            st_q.rwO   <= 1'b1;
            st_q.vec   <= tlp_pkg::TLP_VEC_TIMER;
        end else begin
            st_q <= st_d;
        end
    end

    assign vecAddr       = st_q.vec;
    assign addressStrobe = st_q.asO;
    assign dataStrobe    = st_q.dsO;
    assign rwOut         = st_q.rwO;
    assign busOe         = st_q.oeO;
    assign coreHalt      = (st_q.mode != tlp_pkg::TLP_RUN);

    // ========================================================================
    // Assertions
    // ========================================================================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_stop_entry_bits: assert property (wrMode && wdat[1] && st_q.mode == tlp_pkg::TLP_RUN
        |=> st_q.mode == tlp_pkg::TLP_STOP && !st_q.tReq && st_q.tMask && !st_q.ccI
            && st_q.count == 8'hf0)
        else $error("Stop entry did not set timer and mask bits.");
    a_stop_no_count: assert property (st_q.mode == tlp_pkg::TLP_STOP && $past(st_q.mode)
        == tlp_pkg::TLP_STOP |-> $stable(st_q.count) && !pif.tickIn)
        else $error("Timer moved during stop.");
    a_stop_timer_nowake: assert property (st_q.mode == tlp_pkg::TLP_STOP && !st_q.extLatch
        |=> st_q.mode == tlp_pkg::TLP_STOP)
        else $error("Stop left without external interrupt.");
    a_lowpwr_pins_idle: assert property (st_q.mode != tlp_pkg::TLP_RUN
        |-> !addressStrobe && !dataStrobe && rwOut && !busOe)
        else $error("Bus pins not idle in low power.");
    a_wait_timer_exit: assert property (st_q.mode == tlp_pkg::TLP_WAIT && timerPend
        && !st_q.extLatch |=> st_q.mode == tlp_pkg::TLP_RUN ##1 vecAddr == 13'h1ff6)
        else $error("Timer wake from wait used wrong vector.");
    a_wait_clears_i: assert property (st_q.mode == tlp_pkg::TLP_WAIT
        && $past(st_q.mode) == tlp_pkg::TLP_RUN |-> !st_q.ccI)
        else $error("Wait entry left I set.");
    a_wait_ext_first: assert property (st_q.mode == tlp_pkg::TLP_WAIT && st_q.extLatch
        |=> st_q.mode == tlp_pkg::TLP_RUN && !st_q.waitTimerVec ##1 vecAddr == 13'h1ffa)
        else $error("External interrupt not first after wait.");
    a_zero_sets_req: assert property (zeroStep && !wrCount && !wrMode |=> st_q.tReq
        && st_q.count == 8'h00)
        else $error("Step to zero did not set request.");
    a_count_wraps: assert property (pif.tickOut && st_q.count == 8'h00 && !wrDo
        |=> st_q.count == 8'hff && $stable(st_q.tReq))
        else $error("Counter did not keep counting past zero.");
    a_irq_gate: assert property (st_q.mode == tlp_pkg::TLP_RUN && st_q.tReq
        && (st_q.tMask || st_q.ccI) && !st_q.extLatch |-> !cpuIrq)
        else $error("Timer interrupt raised while masked.");
    a_ctrl_bit3_zero: assert property (avs_read && !avs_waitrequest
        && avs_address == tlp_pkg::TLP_OFF_CTRL |-> avs_readdata[3] == 1'b0)
        else $error("Prescaler clear bit read back as one.");
    a_count_write: assert property (wrCount && st_q.mode != tlp_pkg::TLP_STOP
        |=> st_q.count == $past(wdat))
        else $error("Counter write not loaded.");

    c_stop_wake: cover property (st_q.mode == tlp_pkg::TLP_STOP
        ##1 st_q.mode == tlp_pkg::TLP_RUN);
    c_wait_timer: cover property (st_q.mode == tlp_pkg::TLP_WAIT && timerPend);
    c_zero_step: cover property (zeroStep);
    c_irq_take: cover property (irqTake && vecAddr == 13'h1ff8);
    c_wait_ext: cover property (st_q.mode == tlp_pkg::TLP_WAIT && st_q.extLatch
        ##1 st_q.mode == tlp_pkg::TLP_RUN && vecAddr == 13'h1ffa);

endmodule : tlp_timer_lpm

// file: sim/tb.sv
// Self-checking testbench of the timer with stop and wait low-power modes.
`timescale 1ns/1ns
module tb;
    logic        clk_sys;
    logic        rst_n;
    logic [3:0]  adr;
    logic        rdEn;
    logic        wrEn;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [31:0] rdata;
    logic [31:0] rd;
    logic        waitReq;
    logic        timerPin;
    logic        extIrq_n;
    logic        intAck;
    logic        cpuIrq;
    logic [12:0] vecAddr;
    logic [4:0]  pins;
    logic        coreHalt;
    int          errCount;
    int          checkCount;
    int          i;

    tlp_timer_lpm #(.CYC_DIV(5)) i_tlp_timer_lpm (
        .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(adr), .avs_read(rdEn),
        .avs_write(wrEn), .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(waitReq), .timerPin(timerPin), .extIrq_n(extIrq_n),
        .intAck(intAck), .coreRw(1'b0), .coreBusOe(1'b1), .cpuIrq(cpuIrq),
        .vecAddr(vecAddr), .addressStrobe(pins[4]), .dataStrobe(pins[3]), .rwOut(pins[2]),
        .busOe(pins[1]), .coreHalt(coreHalt));
    assign pins[0] = coreHalt;

    // ========================================================================
    // Tasks
    // ========================================================================
    task automatic finishTest();
        $display("Checks %0d, errors %0d", checkCount, errCount);
        if (errCount == 0 && checkCount > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finishTest

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            errCount++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Holds the request until waitrequest is sampled low, then releases it.
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
                       input logic [3:0] b);
        @(posedge clk_sys);
        adr <= a;
        wdata <= {24'h0, d};
        be <= b;
        wrEn <= w;
        rdEn <= !w;
        do @(posedge clk_sys); while (waitReq !== 1'b0);
        rd = rdata;
        wrEn <= 1'b0;
        rdEn <= 1'b0;
    endtask : acc

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        acc(1'b1, a, d, 4'h1);
    endtask : wr

    task automatic rc(input logic [3:0] a, input logic [7:0] e, input string nm);
        acc(1'b0, a, 8'h00, 4'h1);
        chk(nm, rd, {24'h0, e});
    endtask : rc

    task automatic irqAck(input logic [12:0] e, input string nm);
        for (i = 0; i < 100 && cpuIrq !== 1'b1; i++) @(posedge clk_sys);
        extIrq_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk(nm, 32'(vecAddr), 32'(e));
        intAck <= 1'b1;
        @(posedge clk_sys);
        intAck <= 1'b0;
    endtask : irqAck

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        errCount++;
        finishTest();
    end

    // ========================================================================
    // Tests
    // ========================================================================
    initial begin
        {rst_n, adr, rdEn, wrEn, wdata, be, intAck} = '0;
        {timerPin, extIrq_n, errCount, checkCount} = {2'b11, 64'h0};
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        rc(tlp_pkg::TLP_OFF_CTRL, 8'h40, "ctrl reset");
        rc(tlp_pkg::TLP_OFF_COUNT, 8'hf0, "count reset");
        rc(tlp_pkg::TLP_OFF_MODE, 8'h01, "mode reset");
        rc(4'hc, 8'h00, "unmapped");
        acc(1'b1, tlp_pkg::TLP_OFF_CTRL, 8'h3f, 4'h0);
        rc(tlp_pkg::TLP_OFF_CTRL, 8'h40, "byteenable");
        wr(tlp_pkg::TLP_OFF_CTRL, 8'hff);
        rc(tlp_pkg::TLP_OFF_CTRL, 8'hf7, "ctrl rw");
        wr(tlp_pkg::TLP_OFF_CTRL, 8'h60);
        wr(tlp_pkg::TLP_OFF_COUNT, 8'h10);
        repeat (50) @(posedge clk_sys);
        rc(tlp_pkg::TLP_OFF_COUNT, 8'h10, "disabled");
        wr(tlp_pkg::TLP_OFF_CTRL, 8'h30);
        wr(tlp_pkg::TLP_OFF_COUNT, 8'h10);
        repeat (4) begin
            timerPin <= 1'b0;
            repeat (10) @(posedge clk_sys);
            timerPin <= 1'b1;
            repeat (10) @(posedge clk_sys);
        end
        rc(tlp_pkg::TLP_OFF_COUNT, 8'h0c, "pin edges");
        timerPin <= 1'b0;
        wr(tlp_pkg::TLP_OFF_CTRL, 8'h10);
        wr(tlp_pkg::TLP_OFF_COUNT, 8'h10);
        repeat (50) @(posedge clk_sys);
        rc(tlp_pkg::TLP_OFF_COUNT, 8'h10, "gated");
        wr(tlp_pkg::TLP_OFF_CTRL, 8'h0f);
        wr(tlp_pkg::TLP_OFF_COUNT, 8'h10);
        repeat (200) @(posedge clk_sys);
        acc(1'b0, tlp_pkg::TLP_OFF_COUNT, 8'h00, 4'h1);
        chk("divide 128", 32'(rd[7:1]), 32'h08);
        wr(tlp_pkg::TLP_OFF_CTRL, 8'h00);
        wr(tlp_pkg::TLP_OFF_COUNT, 8'h03);
        repeat (100) @(posedge clk_sys);
        rc(tlp_pkg::TLP_OFF_CTRL, 8'h80, "zero flag");
        chk("irq masked by I", 32'(cpuIrq), 32'h0);
        acc(1'b0, tlp_pkg::TLP_OFF_COUNT, 8'h00, 4'h1);
        chk("past zero", 32'(rd[7]), 32'h1);
        wr(tlp_pkg::TLP_OFF_MODE, 8'h02);
        rc(tlp_pkg::TLP_OFF_CTRL, 8'h40, "stop ctrl");
        rc(tlp_pkg::TLP_OFF_MODE, 8'h02, "stop mode");
        chk("stop pins", 32'(pins), 32'h05);
        repeat (50) @(posedge clk_sys);
        rc(tlp_pkg::TLP_OFF_COUNT, 8'hf0, "stop count");
        wr(tlp_pkg::TLP_OFF_CTRL, 8'h80);
        repeat (20) @(posedge clk_sys);
        rc(tlp_pkg::TLP_OFF_MODE, 8'h02, "stop holds");
        extIrq_n <= 1'b0;
        irqAck(13'h1ffa, "stop wake");
        chk("run pins", 32'(pins[2:0]), 32'h2);
        extIrq_n <= 1'b0;
        wr(tlp_pkg::TLP_OFF_MODE, 8'h04);
        irqAck(13'h1ffa, "ext first");
        wr(tlp_pkg::TLP_OFF_MODE, 8'h00);
        irqAck(13'h1ff8, "normal vector");
        wr(tlp_pkg::TLP_OFF_CTRL, 8'h00);
        wr(tlp_pkg::TLP_OFF_COUNT, 8'h02);
        wr(tlp_pkg::TLP_OFF_MODE, 8'h04);
        @(posedge clk_sys);
        chk("wait pins", 32'(pins), 32'h05);
        irqAck(13'h1ff6, "wait vector");
        rc(tlp_pkg::TLP_OFF_CTRL, 8'h80, "flag held");
        wr(tlp_pkg::TLP_OFF_MODE, 8'h00);
        wr(tlp_pkg::TLP_OFF_CTRL, 8'hc0);
        repeat (2) @(posedge clk_sys);
        chk("timer mask", 32'(cpuIrq), 32'h0);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rc(tlp_pkg::TLP_OFF_CTRL, 8'h40, "ctrl ext reset");
        finishTest();
    end
endmodule : tb
